// *** src/hbch_pkg.sv ***
// constants for the host bridge configuration header
package hbch_pkg;
   // dword indices of the configuration port (byte offset = 4 * index)
   localparam logic [5:0] DW_CMD_STS = 6'h01;
   localparam logic [5:0] DW_CLASS = 6'h02;
   localparam logic [5:0] DW_HDR = 6'h03;
   localparam logic [5:0] DW_CAP = 6'h0d;
   // byte offsets as printed
   localparam logic [7:0] OFS_STATUS = 8'h06;
   localparam logic [7:0] OFS_REVISION = 8'h08;
   localparam logic [7:0] OFS_SUB_CLASS = 8'h0a;
   localparam logic [7:0] OFS_BASE_CLASS = 8'h0b;
   localparam logic [7:0] OFS_LATENCY = 8'h0d;
   localparam logic [7:0] OFS_HEADER = 8'h0e;
   localparam logic [7:0] OFS_CAP_PTR = 8'h34;
   // status and command field positions
   localparam int STS_PARITY_ERR = 15;
   localparam int STS_SYS_ERR = 14;
   localparam int STS_MASTER_ABORT = 13;
   localparam int STS_TARGET_ABORT = 12;
   localparam int STS_TGT_ABORT_SIG = 11;
   localparam int STS_SEL_TIMING_HI = 10;
   localparam int STS_SEL_TIMING_LO = 9;
   localparam int STS_DATA_PARITY = 8;
   localparam int STS_BACK_TO_BACK = 7;
   localparam int STS_CAP_LIST = 4;
   localparam int CMD_SERR_ENABLE = 8;
   // reset and fixed values
   localparam logic [15:0] STS_RESET = 16'h0090;
   localparam logic [15:0] CMD_RESET = 16'h0006;
   localparam logic [1:0] SEL_TIMING_FAST = 2'h0;
   localparam logic [7:0] SUB_CLASS_VAL = 8'h00;
   localparam logic [7:0] BASE_CLASS_VAL = 8'h06;
   localparam logic [7:0] LATENCY_VAL = 8'h00;
   localparam logic [7:0] HEADER_VAL = 8'h00;
   localparam logic [7:0] CAP_PTR_VAL = 8'h88;
   // arbitrary neutral revision code
   localparam logic [7:0] REVISION_VAL = 8'h5a;
   // flag vector order inside the sticky module
   localparam int FLG_SYS_ERR = 2;
   localparam int FLG_MASTER_ABORT = 1;
   localparam int FLG_TARGET_ABORT = 0;
endpackage : hbch_pkg

// *** src/hbch_sticky_flags.sv ***
// sticky write-one-to-clear status flags, set wins over clear
`timescale 1ns/1ps
module hbch_sticky_flags
   import hbch_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // events and clears
   input wire logic [2:0] setPulse,
   input wire logic [2:0] clrMask,
   // flag state
   output logic [2:0] flags
);
   logic [2:0] flags_reg;
   logic [2:0] flags_next;

   // an event in the clearing cycle must survive
   assign flags_next = (flags_reg & ~clrMask) | setPulse;
   assign flags = flags_reg;

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         flags_reg <= 3'h0;
      end
      else
      begin
         flags_reg <= flags_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   property p_set_wins;
      @(posedge sys_clk) disable iff (rst)
      (setPulse != 3'h0) |=> ((flags_reg & $past(setPulse)) == $past(setPulse));
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("set event lost");

   property p_hold;
      @(posedge sys_clk) disable iff (rst)
      (clrMask == 3'h0 && setPulse == 3'h0) |=> (flags_reg == $past(flags_reg));
   endproperty
   a_hold: assert property (p_hold) else $error("flag changed without cause");
endmodule : hbch_sticky_flags

// *** src/hbch_serr_msg.sv ***
// error message generator toward the hub interface
`timescale 1ns/1ps
module hbch_serr_msg
   import hbch_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // error source and enable
   input wire logic errCondition,
   input wire logic serrEnable,
   // message out
   output logic serrMsg
);
   logic serrMsg_reg;
   logic serrMsg_next;

   // only enabled conditions become messages
   assign serrMsg_next = errCondition & serrEnable;
   assign serrMsg = serrMsg_reg;

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         serrMsg_reg <= 1'b0;
      end
      else
      begin
         serrMsg_reg <= serrMsg_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   property p_msg_gated;
      @(posedge sys_clk) disable iff (rst)
      serrMsg_reg |-> $past(errCondition) && $past(serrEnable);
   endproperty
   a_msg_gated: assert property (p_msg_gated) else $error("message without enable");

   property p_msg_sent;
      @(posedge sys_clk) disable iff (rst)
      (errCondition && serrEnable) |=> serrMsg_reg;
   endproperty
   a_msg_sent: assert property (p_msg_sent) else $error("enabled error not sent");
endmodule : hbch_serr_msg

// *** src/hbch_config_header.sv ***
// identification and status part of the host bridge configuration header
`timescale 1ns/1ps
module hbch_config_header
   import hbch_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // configuration access port, dword addressed
   input wire logic cfgRd,
   input wire logic cfgWr,
   input wire logic [5:0] cfgDwAddr,
   input wire logic [3:0] cfgByteEn,
   input wire logic [31:0] cfgWrData,
   output logic [31:0] cfgRdData,
   output logic cfgRdValid,
   // hub interface events
   input wire logic errCondition,
   input wire logic masterAbortCpl,
   input wire logic targetAbortCpl,
   output logic serrMsgReq,
   // state view
   output logic serrEnableOut
);
   ////////////////////////////////////////////////////////////////////////////
   // decode helpers

   // a write that reaches one byte lane of one dword
   function automatic logic laneWrite(input logic wr, input logic [5:0] addr,
                                      input logic [5:0] dw, input logic [3:0] be,
                                      input int lane);
      laneWrite = wr && (addr == dw) && be[lane];
   endfunction : laneWrite

   ////////////////////////////////////////////////////////////////////////////
   // storage

   logic serrEnable_reg;
   logic serrEnable_next;
   logic [31:0] rdData_reg;
   logic [31:0] rdData_next;
   logic rdValid_reg;
   logic [5:0] rdAddr_reg;
   logic [2:0] flags;
   logic [2:0] setPulse;
   logic [2:0] clrMask;
   logic serrMsg;

   ////////////////////////////////////////////////////////////////////////////
   // write decode

   wire cmdHiWrite = laneWrite(cfgWr, cfgDwAddr, DW_CMD_STS, cfgByteEn, 1);
   wire stsHiWrite = laneWrite(cfgWr, cfgDwAddr, DW_CMD_STS, cfgByteEn, 3);

   // only the enable bit of the command word is kept here
   assign serrEnable_next = cmdHiWrite ? cfgWrData[CMD_SERR_ENABLE] : serrEnable_reg;

   // status sits in the upper half of the dword; write of one clears
   assign clrMask[FLG_SYS_ERR] = stsHiWrite & cfgWrData[16 + STS_SYS_ERR];
   assign clrMask[FLG_MASTER_ABORT] = stsHiWrite & cfgWrData[16 + STS_MASTER_ABORT];
   assign clrMask[FLG_TARGET_ABORT] = stsHiWrite & cfgWrData[16 + STS_TARGET_ABORT];

   ////////////////////////////////////////////////////////////////////////////
   // event sources

   // flag tracks the message actually sent, not the raw condition
   assign setPulse[FLG_SYS_ERR] = serrMsg;
   assign setPulse[FLG_MASTER_ABORT] = masterAbortCpl;
   assign setPulse[FLG_TARGET_ABORT] = targetAbortCpl;

   hbch_serr_msg u_serr_msg (
      .sys_clk(sys_clk),
      .rst(rst),
      .errCondition(errCondition),
      .serrEnable(serrEnable_reg),
      .serrMsg(serrMsg)
   );

   hbch_sticky_flags u_flags (
      .sys_clk(sys_clk),
      .rst(rst),
      .setPulse(setPulse),
      .clrMask(clrMask),
      .flags(flags)
   );

   ////////////////////////////////////////////////////////////////////////////
   // read assembly

   wire [15:0] statusWord;
   wire [15:0] commandWord;
   wire [31:0] classWord;
   wire [31:0] headerWord;
   wire [31:0] capWord;

   // hardwired bits never have storage, so writes cannot reach them
   assign statusWord = {
      1'b0,
      flags[FLG_SYS_ERR],
      flags[FLG_MASTER_ABORT],
      flags[FLG_TARGET_ABORT],
      1'b0,
      SEL_TIMING_FAST,
      1'b0,
      1'b1,
      2'h0,
      1'b1,
      4'h0
   };

   assign commandWord = {7'h00, serrEnable_reg, CMD_RESET[7:0]};

   assign classWord = {BASE_CLASS_VAL, SUB_CLASS_VAL, 8'h00, REVISION_VAL};

   // latency and header bytes are constants with no storage behind them
   assign headerWord = {8'h00, HEADER_VAL, LATENCY_VAL, 8'h00};

   assign capWord = {24'h000000, CAP_PTR_VAL};

   // unmapped dwords read as zero
   assign rdData_next = (cfgDwAddr == DW_CMD_STS) ? {statusWord, commandWord} :
                        (cfgDwAddr == DW_CLASS) ? classWord :
                        (cfgDwAddr == DW_HDR) ? headerWord :
                        (cfgDwAddr == DW_CAP) ? capWord :
                        32'h00000000;

   ////////////////////////////////////////////////////////////////////////////
   // registers

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         serrEnable_reg <= CMD_RESET[CMD_SERR_ENABLE];
      end
      else
      begin
         serrEnable_reg <= serrEnable_next;
      end
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         rdData_reg <= 32'h00000000;
         rdValid_reg <= 1'b0;
         rdAddr_reg <= 6'h00;
      end
      else
      begin
         rdValid_reg <= cfgRd;
         if (cfgRd)
         begin
            rdData_reg <= rdData_next;
            rdAddr_reg <= cfgDwAddr;
         end
      end
   end

   // serrMsg comes from a flop inside the generator
   assign serrMsgReq = serrMsg;
   assign cfgRdData = rdData_reg;
   assign cfgRdValid = rdValid_reg;
   assign serrEnableOut = serrEnable_reg;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   wire stsRead = rdValid_reg && (rdAddr_reg == DW_CMD_STS);
   wire clsRead = rdValid_reg && (rdAddr_reg == DW_CLASS);
   wire hdrRead = rdValid_reg && (rdAddr_reg == DW_HDR);

   property p_sse_set;
      serrMsg |=> flags[FLG_SYS_ERR] ##1 (flags[FLG_SYS_ERR] || $past(clrMask[FLG_SYS_ERR]));
   endproperty
   a_sse_set: assert property (p_sse_set) else $error("sent message did not flag");

   property p_sse_clear;
      (clrMask[FLG_SYS_ERR] && !serrMsg) |=> !flags[FLG_SYS_ERR];
   endproperty
   a_sse_clear: assert property (p_sse_clear) else $error("system error flag not cleared");

   property p_sse_keep;
      (flags[FLG_SYS_ERR] && cfgWr && cfgDwAddr == DW_CMD_STS && !cfgWrData[30]) |=>
         flags[FLG_SYS_ERR];
   endproperty
   a_sse_keep: assert property (p_sse_keep) else $error("zero write cleared flag");

   property p_master_abort_received_set;
      masterAbortCpl |=> flags[FLG_MASTER_ABORT];
   endproperty
   a_master_abort_received_set: assert property (p_master_abort_received_set) else $error("master abort not flagged");

   property p_target_abort_received_set;
      targetAbortCpl |=> flags[FLG_TARGET_ABORT];
   endproperty
   a_target_abort_received_set: assert property (p_target_abort_received_set) else $error("target abort not flagged");

   property p_abort_clear;
      (clrMask[FLG_MASTER_ABORT] && !masterAbortCpl) |=> !flags[FLG_MASTER_ABORT];
   endproperty
   a_abort_clear: assert property (p_abort_clear) else $error("abort flag not cleared");

   property p_target_abort_received_clear;
      (clrMask[FLG_TARGET_ABORT] && !targetAbortCpl) |=> !flags[FLG_TARGET_ABORT];
   endproperty
   a_target_abort_received_clear: assert property (p_target_abort_received_clear) else $error("target flag not cleared");

   property p_zero_bits;
      stsRead |-> !rdData_reg[16 + STS_PARITY_ERR] && !rdData_reg[16 + STS_TGT_ABORT_SIG]
                  && !rdData_reg[16 + STS_DATA_PARITY];
   endproperty
   a_zero_bits: assert property (p_zero_bits) else $error("hardwired zero bit set");

   property p_sel_timing;
      stsRead |-> rdData_reg[16 + STS_SEL_TIMING_HI:16 + STS_SEL_TIMING_LO] == 2'h0;
   endproperty
   a_sel_timing: assert property (p_sel_timing) else $error("select timing not fast");

   property p_b2b;
      stsRead |-> rdData_reg[16 + STS_BACK_TO_BACK] && rdData_reg[16 + STS_CAP_LIST];
   endproperty
   a_b2b: assert property (p_b2b) else $error("capability bits not one");

   property p_cap_ptr;
      (cfgRd && cfgDwAddr == DW_CAP) |=> cfgRdValid && cfgRdData == 32'h00000088;
   endproperty
   a_cap_ptr: assert property (p_cap_ptr) else $error("capability pointer wrong");

   property p_reset_value;
      @(posedge sys_clk) $fell(rst) |-> statusWord == 16'h0090;
   endproperty
   a_reset_value: assert property (p_reset_value) else $error("status reset value wrong");

   property p_class_word;
      clsRead |-> rdData_reg == {8'h06, 8'h00, 8'h00, REVISION_VAL};
   endproperty
   a_class_word: assert property (p_class_word) else $error("class dword wrong");

   property p_header_word;
      hdrRead |-> rdData_reg == 32'h00000000;
   endproperty
   a_header_word: assert property (p_header_word) else $error("latency or header nonzero");

   property p_reserved;
      stsRead |-> rdData_reg[22:21] == 2'h0 && rdData_reg[19:16] == 4'h0;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bit set");

   property p_read_latency;
      cfgRd |=> cfgRdValid ##1 (cfgRdValid == $past(cfgRd));
   endproperty
   a_read_latency: assert property (p_read_latency) else $error("read answer late");

   property p_rd_hold;
      !cfgRd |=> $stable(cfgRdData);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");

   property p_enable_write;
      cmdHiWrite |=> serrEnable_reg == $past(cfgWrData[CMD_SERR_ENABLE]);
   endproperty
   a_enable_write: assert property (p_enable_write) else $error("enable bit not written");

   property p_enable_hold;
      !cmdHiWrite |=> $stable(serrEnable_reg);
   endproperty
   a_enable_hold: assert property (p_enable_hold) else $error("enable bit moved without write");

   property p_no_msg_disabled;
      !serrEnable_reg |=> !serrMsg;
   endproperty
   a_no_msg_disabled: assert property (p_no_msg_disabled) else $error("message while disabled");

   property p_sse_quiet;
      (!serrEnable_reg && !serrMsg && !flags[FLG_SYS_ERR]) |=>
         !flags[FLG_SYS_ERR] ##1 !flags[FLG_SYS_ERR];
   endproperty
   a_sse_quiet: assert property (p_sse_quiet) else $error("flag set while disabled");

   property p_master_abort_received_keep;
      (flags[FLG_MASTER_ABORT] && !clrMask[FLG_MASTER_ABORT]) |=> flags[FLG_MASTER_ABORT];
   endproperty
   a_master_abort_received_keep: assert property (p_master_abort_received_keep) else $error("master abort flag lost");

   property p_target_abort_received_keep;
      (flags[FLG_TARGET_ABORT] && !clrMask[FLG_TARGET_ABORT]) |=> flags[FLG_TARGET_ABORT];
   endproperty
   a_target_abort_received_keep: assert property (p_target_abort_received_keep) else $error("target abort flag lost");

   property p_cmd_word;
      stsRead |-> rdData_reg[15:9] == 7'h00 && rdData_reg[7:0] == 8'h06;
   endproperty
   a_cmd_word: assert property (p_cmd_word) else $error("command word fixed bits wrong");

   property p_header_type;
      hdrRead |-> rdData_reg[23:16] == 8'h00;
   endproperty
   a_header_type: assert property (p_header_type) else $error("header type nonzero");

   property p_cap_list;
      stsRead |-> rdData_reg[16 + STS_CAP_LIST];
   endproperty
   a_cap_list: assert property (p_cap_list) else $error("capability list bit not one");

   property p_valid_source;
      cfgRdValid |-> $past(cfgRd);
   endproperty
   a_valid_source: assert property (p_valid_source) else $error("read answer without request");

   property p_unmapped;
      (rdValid_reg && rdAddr_reg != DW_CMD_STS && rdAddr_reg != DW_CLASS && rdAddr_reg != DW_HDR
         && rdAddr_reg != DW_CAP) |-> rdData_reg == 32'h00000000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped dword nonzero");

   cover property (serrMsg ##1 stsRead);
   cover property (masterAbortCpl && clrMask[FLG_MASTER_ABORT]);
   cover property (targetAbortCpl ##[1:4] clrMask[FLG_TARGET_ABORT]);
   cover property (errCondition && !serrEnable_reg);
   cover property (cmdHiWrite && !cfgWrData[CMD_SERR_ENABLE]);
endmodule : hbch_config_header

// *** sim/hbch_hub_model.sv ***
// hub interface partner: abort completions on demand, error message counter
`timescale 1ns/1ps
module hbch_hub_model
   import hbch_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // completion requests from the bench
   input wire logic sendMaster,
   input wire logic sendTarget,
   // hub lines
   input wire logic serrMsg,
   output logic masterAbortCpl,
   output logic targetAbortCpl,
   // observed traffic
   output logic [7:0] msgCount
);
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         masterAbortCpl <= 1'b0;
         targetAbortCpl <= 1'b0;
         msgCount <= 8'h00;
      end
      else
      begin
         masterAbortCpl <= sendMaster;
         targetAbortCpl <= sendTarget;
         msgCount <= msgCount + {7'h00, serrMsg};
      end
   end
endmodule : hbch_hub_model

// *** sim/tb_hbch_config_header.sv ***
// self-checking bench for the host bridge configuration header
`timescale 1ns/1ps
module tb_hbch_config_header
   import hbch_pkg::*;
;
   logic sys_clk, rst, cfgRd, cfgWr, cfgRdValid, errCondition, serrMsgReq, serrEnableOut;
   logic masterAbortCpl, targetAbortCpl, sendMaster, sendTarget;
   logic [5:0] cfgDwAddr;
   logic [3:0] cfgByteEn;
   logic [31:0] cfgWrData, cfgRdData;
   logic [7:0] msgCount;
   int fails = 0;
   int n_compared = 0;

   always #25 sys_clk = ~sys_clk;

   hbch_config_header i_dut (.sys_clk(sys_clk), .rst(rst), .cfgRd(cfgRd), .cfgWr(cfgWr),
      .cfgDwAddr(cfgDwAddr), .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData), .cfgRdData(cfgRdData),
      .cfgRdValid(cfgRdValid), .errCondition(errCondition), .masterAbortCpl(masterAbortCpl),
      .targetAbortCpl(targetAbortCpl), .serrMsgReq(serrMsgReq), .serrEnableOut(serrEnableOut));

   hbch_hub_model i_hub (.sys_clk(sys_clk), .rst(rst), .sendMaster(sendMaster), .sendTarget(sendTarget),
      .serrMsg(serrMsgReq), .masterAbortCpl(masterAbortCpl), .targetAbortCpl(targetAbortCpl),
      .msgCount(msgCount));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : tally_and_finish

   task automatic cfg_write(input logic [5:0] dw, input logic [3:0] be, input logic [31:0] data);
      @(posedge sys_clk);
      cfgWr <= 1'b1;
      cfgDwAddr <= dw;
      cfgByteEn <= be;
      cfgWrData <= data;
      @(posedge sys_clk);
      cfgWr <= 1'b0;
      cfgDwAddr <= ~dw;
      cfgWrData <= ~data;
   endtask : cfg_write

   // read a dword and compare it; valid is awaited for a few cycles only
   task automatic rd_check(input logic [5:0] dw, input logic [31:0] exp);
      logic seen;
      seen = 1'b0;
      @(posedge sys_clk);
      cfgRd <= 1'b1;
      cfgDwAddr <= dw;
      @(posedge sys_clk);
      cfgRd <= 1'b0;
      cfgDwAddr <= ~dw;
      for (int i = 0; i < 4 && !seen; i++)
      begin
         #1;
         if (cfgRdValid === 1'b1)
         begin
            seen = 1'b1;
            n_compared++;
            if (cfgRdData !== exp)
            begin
               fails++;
               $display("mismatch at %0t: dword %h read %h, expected %h", $time, dw, cfgRdData, exp);
            end
         end
         else
            @(posedge sys_clk);
      end
      if (!seen)
      begin
         fails++;
         $display("mismatch at %0t: no read answer for dword %h", $time, dw);
      end
   endtask : rd_check

   task automatic chk_count(input logic [7:0] exp);
      n_compared++;
      if (msgCount !== exp)
      begin
         fails++;
         $display("mismatch at %0t: %0d error messages, expected %0d", $time, msgCount, exp);
      end
   endtask : chk_count

   task automatic chk_enable(input logic exp);
      n_compared++;
      if (serrEnableOut !== exp)
      begin
         fails++;
         $display("mismatch at %0t: message enable %b, expected %b", $time, serrEnableOut, exp);
      end
   endtask : chk_enable

   // error condition held for n cycles, one message per cycle while the enable bit is set
   task automatic pulse_err(input int n);
      @(posedge sys_clk);
      errCondition <= 1'b1;
      repeat (n) @(posedge sys_clk);
      errCondition <= 1'b0;
      repeat (4) @(posedge sys_clk);
   endtask : pulse_err

   task automatic pulse_abort(input logic m, input logic t);
      @(posedge sys_clk);
      sendMaster <= m;
      sendTarget <= t;
      @(posedge sys_clk);
      sendMaster <= 1'b0;
      sendTarget <= 1'b0;
      repeat (4) @(posedge sys_clk);
   endtask : pulse_abort

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      sys_clk = 1'b0;
      rst = 1'b1;
      {cfgRd, cfgWr, errCondition, sendMaster, sendTarget} = 5'h00;
      cfgDwAddr = 6'h00;
      cfgByteEn = 4'h0;
      cfgWrData = 32'h0000_0000;
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      rd_check(DW_CMD_STS, 32'h0090_0006);
      rd_check(DW_CLASS, {16'h0600, 8'h00, REVISION_VAL});
      rd_check(DW_HDR, 32'h0000_0000);
      rd_check(DW_CAP, {24'h00_0000, CAP_PTR_VAL});
      rd_check(6'h3f, 32'h0000_0000);
      // all ones into the command, class and header dwords: only the enable bit may stick
      cfg_write(DW_CMD_STS, 4'hf, 32'hffff_ffff);
      cfg_write(DW_CLASS, 4'hf, 32'hffff_ffff);
      cfg_write(DW_HDR, 4'hf, 32'hffff_ffff);
      rd_check(DW_CMD_STS, 32'h0090_0106);
      rd_check(DW_CLASS, {16'h0600, 8'h00, REVISION_VAL});
      rd_check(DW_HDR, 32'h0000_0000);
      chk_enable(1'b1);
      pulse_err(1);
      chk_count(8'h01);
      rd_check(DW_CMD_STS, 32'h4090_0106);
      cfg_write(DW_CMD_STS, 4'h8, 32'h0000_0000);
      rd_check(DW_CMD_STS, 32'h4090_0106);
      cfg_write(DW_CMD_STS, 4'h8, 32'h4000_0000);
      rd_check(DW_CMD_STS, 32'h0090_0106);
      pulse_err(2);
      chk_count(8'h03);
      pulse_abort(1'b1, 1'b0);
      rd_check(DW_CMD_STS, 32'h6090_0106);
      pulse_abort(1'b0, 1'b1);
      rd_check(DW_CMD_STS, 32'h7090_0106);
      cfg_write(DW_CMD_STS, 4'h8, 32'h2000_0000);
      rd_check(DW_CMD_STS, 32'h5090_0106);
      cfg_write(DW_CMD_STS, 4'h8, 32'h5000_0000);
      rd_check(DW_CMD_STS, 32'h0090_0106);
      // abort and its clear land on one edge: the event must survive
      fork
         pulse_abort(1'b1, 1'b0);
         begin
            @(posedge sys_clk);
            cfg_write(DW_CMD_STS, 4'h8, 32'h2000_0000);
         end
      join
      rd_check(DW_CMD_STS, 32'h2090_0106);
      cfg_write(DW_CMD_STS, 4'h8, 32'h2000_0000);
      // enable off: error conditions go unreported
      cfg_write(DW_CMD_STS, 4'h2, 32'h0000_0000);
      pulse_err(1);
      chk_count(8'h03);
      chk_enable(1'b0);
      rd_check(DW_CMD_STS, 32'h0090_0006);
      // reset in mid-run with a flag standing
      pulse_abort(1'b1, 1'b1);
      @(posedge sys_clk);
      rst <= 1'b1;
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      rd_check(DW_CMD_STS, 32'h0090_0006);
      tally_and_finish();
   end

   // full run takes well under 400 cycles
   initial
   begin
      repeat (3000) @(posedge sys_clk);
      fails++;
      $display("mismatch at %0t: watchdog expired", $time);
      tally_and_finish();
   end
endmodule : tb_hbch_config_header
